// [design/wbl_pkg.sv]
// shared constants and carriers for the white-balance pixel output path
package wbl_pkg;
  localparam int ADDR_W    = 10;
  localparam int DATA_W    = 8;
  localparam int LANE_W    = 7;
  localparam int LUT_DEPTH = 256;
  localparam int LUT_IDX_W = 8;
  localparam int NUM_LUTS  = 3;

  localparam logic [ADDR_W-1:0] REG_CTRL   = 10'h000;
  localparam logic [ADDR_W-1:0] REG_PAGE   = 10'h001;
  localparam logic [ADDR_W-1:0] REG_STATUS = 10'h002;
  localparam logic [ADDR_W-1:0] LUT_BASE   = 10'h100;
  localparam logic [ADDR_W-1:0] LUT_LAST   = 10'h1FF;

  localparam int CTRL_WB_EN   = 0;
  localparam int CTRL_RELOAD  = 1;
  localparam int CTRL_MAP_OVR = 2;
  localparam int CTRL_MAP_SEL = 3;
  localparam int CTRL_OUT18   = 4;
  localparam int CTRL_DUAL    = 5;
  localparam int CTRL_DEPTH   = 6;

  localparam int STAT_INIT   = 0;
  localparam int STAT_RELOAD = 1;
  localparam int STAT_LOCKED = 2;
  localparam int STAT_STRAP  = 3;
  localparam int STAT_FULL   = 4;
  localparam int STAT_ORDER  = 7;

  localparam logic [1:0] PAGE_RED   = 2'h0;
  localparam logic [1:0] PAGE_GREEN = 2'h1;
  localparam logic [1:0] PAGE_BLUE  = 2'h2;
  localparam logic [1:0] DEPTH_24   = 2'h0;
  localparam logic [1:0] DEPTH_18   = 2'h1;
  localparam logic [1:0] DEPTH_16   = 2'h2;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  localparam logic [LANE_W-1:0]    CLK_PATTERN = 7'h63;
  localparam logic [LUT_IDX_W-1:0] LAST_ENTRY  = 8'hFF;
  localparam logic [LUT_IDX_W-1:0] MASK_FULL   = 8'hFF;
  localparam logic [LUT_IDX_W-1:0] MASK_6BIT   = 8'hFC;
  localparam logic [LUT_IDX_W-1:0] MASK_5BIT   = 8'hF8;

  typedef struct packed {
    logic       hsync;
    logic       vsync;
    logic       de;
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
  } wbl_pixel_t;

  typedef struct packed {
    logic [LANE_W-1:0] lane3;
    logic [LANE_W-1:0] lane2;
    logic [LANE_W-1:0] lane1;
    logic [LANE_W-1:0] lane0;
  } wbl_link_t;

  typedef struct packed {
    logic                 en;
    logic [1:0]           page;
    logic [LUT_IDX_W-1:0] idx;
    logic [DATA_W-1:0]    data;
  } wbl_lut_wr_t;

  typedef struct packed {
    logic bit_map_select;
    logic out18;
    logic dual;
  } wbl_fmt_t;
endpackage

// [design/wbl_lut_bank.sv]
// three colour lookup tables with a one-cycle pixel lookup stage
`timescale 1ns/100ps
module wbl_lut_bank (
  input  wire logic                          core_clk,
  input  wire logic                          sys_rst,
  input  wire wbl_pkg::wbl_lut_wr_t          lutWr,
  input  wire logic [1:0]                    busPage,
  input  wire logic [wbl_pkg::LUT_IDX_W-1:0] busIdx,
  output logic [wbl_pkg::DATA_W-1:0]         busRdata,
  input  wire logic                          inValid,
  input  wire wbl_pkg::wbl_pixel_t           inPix,
  input  wire logic                          wbEnable,
  input  wire logic [1:0]                    depth,
  output logic                               outValid,
  output wbl_pkg::wbl_pixel_t                outPix
);
  import wbl_pkg::*;

  typedef struct packed {
    logic       valid;
    wbl_pixel_t pix;
  } wbl_lut_state_t;

  wbl_lut_state_t q;
  wbl_lut_state_t next_q;
  logic [DATA_W-1:0] lutMem [NUM_LUTS][LUT_DEPTH];
  logic [LUT_IDX_W-1:0] idxR;
  logic [LUT_IDX_W-1:0] idxG;
  logic [LUT_IDX_W-1:0] idxB;

  // low-depth sources carry zeros below their width, so force them off
  function automatic logic [LUT_IDX_W-1:0] depthMask(input logic [1:0] d, input logic isG);
    if (d == DEPTH_18) begin
      return MASK_6BIT;
    end else if (d == DEPTH_16) begin
      return isG ? MASK_6BIT : MASK_5BIT;
    end
    return MASK_FULL;
  endfunction

  assign idxR = inPix.r & depthMask(depth, 1'b0);
  assign idxG = inPix.g & depthMask(depth, 1'b1);
  assign idxB = inPix.b & depthMask(depth, 1'b0);

  // single-entry writes: a lookup sees either old or new word, never a mix
  always_ff @(posedge core_clk) begin
    if (lutWr.en) begin
      lutMem[lutWr.page][lutWr.idx] <= lutWr.data;
    end
  end

  assign busRdata = (busPage <= PAGE_BLUE) ? lutMem[busPage][busIdx] : '0;

  always_comb begin
    next_q = q;
    next_q.valid = inValid;
    if (inValid) begin
      next_q.pix = inPix;
      if (wbEnable) begin
        next_q.pix.r = lutMem[PAGE_RED][idxR];
        next_q.pix.g = lutMem[PAGE_GREEN][idxG];
        next_q.pix.b = lutMem[PAGE_BLUE][idxB];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign outValid = q.valid;
  assign outPix   = q.pix;

  property p_bypass;
    @(posedge core_clk) disable iff (sys_rst)
    inValid && !wbEnable |=> outValid && (outPix.r == $past(inPix.r))
      && (outPix.b == $past(inPix.b));
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass colour changed");

  property p_sideband;
    @(posedge core_clk) disable iff (sys_rst)
    inValid |=> outValid && (outPix.de == $past(inPix.de))
      && (outPix.hsync == $past(inPix.hsync));
  endproperty
  a_sideband: assert property (p_sideband) else $error("sync not aligned");

  property p_mask18;
    @(posedge core_clk) disable iff (sys_rst)
    (depth == DEPTH_18) |-> (idxR[1:0] == 2'h0) && (idxB[1:0] == 2'h0);
  endproperty
  a_mask18: assert property (p_mask18) else $error("6-bit index not masked");
endmodule

// [design/wbl_frame_former.sv]
// maps corrected pixels onto lane words and splits odd and even pixels
`timescale 1ns/100ps
module wbl_frame_former (
  input  wire logic                       core_clk,
  input  wire logic                       sys_rst,
  input  wire logic                       inValid,
  input  wire wbl_pkg::wbl_pixel_t        inPix,
  input  wire wbl_pkg::wbl_fmt_t          fmt,
  output wbl_pkg::wbl_link_t              linkA,
  output wbl_pkg::wbl_link_t              linkB,
  output logic [wbl_pkg::LANE_W-1:0]      clkOutA,
  output logic [wbl_pkg::LANE_W-1:0]      clkOutB,
  output logic                            frameStrobe
);
  import wbl_pkg::*;

  typedef struct packed {
    wbl_link_t         linkA;
    wbl_link_t         linkB;
    logic [LANE_W-1:0] clkA;
    logic [LANE_W-1:0] clkB;
    logic              strobe;
    logic              evenNext;
    logic              prevDe;
  } wbl_ff_state_t;

  wbl_ff_state_t q;
  wbl_ff_state_t next_q;
  logic          isOdd;

  // bit 0 of a lane word leaves first
  function automatic wbl_link_t mapPixel(input wbl_pixel_t p, input logic hi, input logic o18);
    wbl_link_t m;
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
    r = p.r;
    g = p.g;
    b = p.b;
    if (o18) begin
      r = {2'h0, p.r[7:2]};
      g = {2'h0, p.g[7:2]};
      b = {2'h0, p.b[7:2]};
    end
    if (hi || o18) begin
      m.lane0 = {g[0], r[5:0]};
      m.lane1 = {b[1:0], g[5:1]};
      m.lane2 = {p.de, p.vsync, p.hsync, b[5:2]};
      m.lane3 = o18 ? '0 : {1'b0, b[7:6], g[7:6], r[7:6]};
    end else begin
      m.lane0 = {g[2], r[7:2]};
      m.lane1 = {b[3:2], g[7:3]};
      m.lane2 = {p.de, p.vsync, p.hsync, b[7:4]};
      m.lane3 = {1'b0, b[1:0], g[1:0], r[1:0]};
    end
    return m;
  endfunction

  assign isOdd = (inPix.de && !q.prevDe) || !q.evenNext;

  always_comb begin
    next_q = q;
    next_q.strobe = inValid;
    if (inValid) begin
      next_q.prevDe = inPix.de;
      next_q.clkA = CLK_PATTERN;
      next_q.clkB = fmt.dual ? CLK_PATTERN : '0;
      if (!fmt.dual) begin
        next_q.linkA = mapPixel(inPix, fmt.bit_map_select, fmt.out18);
        next_q.linkB = '0;
        next_q.evenNext = 1'b0;
      end else if (isOdd) begin
        next_q.linkA = mapPixel(inPix, fmt.bit_map_select, fmt.out18);
        next_q.evenNext = 1'b1;
      end else begin
        next_q.linkB = mapPixel(inPix, fmt.bit_map_select, fmt.out18);
        next_q.evenNext = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign linkA       = q.linkA;
  assign linkB       = q.linkB;
  assign clkOutA     = q.clkA;
  assign clkOutB     = q.clkB;
  assign frameStrobe = q.strobe;

  property p_odd_first;
    @(posedge core_clk) disable iff (sys_rst)
    inValid && fmt.dual && inPix.de && !q.prevDe |=> q.evenNext && $stable(linkB);
  endproperty
  a_odd_first: assert property (p_odd_first) else $error("odd pixel not on link A");

  property p_msb_lane3;
    @(posedge core_clk) disable iff (sys_rst)
    inValid && !fmt.dual && fmt.bit_map_select && !fmt.out18
      |=> linkA.lane3[1:0] == $past(inPix.r[7:6]);
  endproperty
  a_msb_lane3: assert property (p_msb_lane3) else $error("msb not on lane three");
endmodule

// [design/wbl_pixel_out.sv]
// white-balance lookup and lvds frame output, top level with register port
//
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/100ps

// How it works
// - every pixel clock period yields exactly one lane frame
// - clock lane word per frame is two high, three low, two high
// - 24 or 18 bit output, map chosen by strap or by control register
// - in 24-bit output, map select high puts colour msbs on lane three, low puts lsbs; 18-bit output leaves lane three zero
// - three tables of 256 eight-bit entries, one per colour
// - white balance on replaces each colour by its table entry
// - entries read and write over the port; no read-back after a reload
// - table contents arrive as a slave on the control port
// - lookup also works for 18-bit and 16-bit colour depth input
// - 6-bit input indexes only 64 entries per colour
// - page select picks which table an entry write lands in
// - after first enable, table writes are refused by default
// - reload enable bit lets later table writes through
// - reloaded entries take effect without a glitch while enabled
// - partial updates allowed while reloading
// - dual link: odd pixels on link A, even on link B, from de rise
module wbl_pixel_out (
  input  wire logic                       core_clk,
  input  wire logic                       sys_rst,
  input  wire logic [wbl_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [wbl_pkg::DATA_W-1:0] regWdata,
  input  wire logic                       regWrite,
  input  wire logic                       regRead,
  output logic [wbl_pkg::DATA_W-1:0]      regRdata,
  input  wire logic                       pixClkIn,
  input  wire wbl_pkg::wbl_pixel_t        pixIn,
  input  wire logic                       output_mode_strap,
  output wbl_pkg::wbl_link_t              linkA,
  output wbl_pkg::wbl_link_t              linkB,
  output logic [wbl_pkg::LANE_W-1:0]      lvds_clock_out_a,
  output logic [wbl_pkg::LANE_W-1:0]      lvds_clock_out_b,
  output logic                            frameStrobe
);
  import wbl_pkg::*;

  typedef struct packed {
    logic              clkMeta;
    logic              clkSync;
    logic              clkPrev;
    wbl_pixel_t        pixMeta;
    wbl_pixel_t        pixSync;
    wbl_pixel_t        pixCap;
    logic              capValid;
    logic              strapMeta;
    logic              strapSync;
    logic [1:0]        strapWait;
    logic              strapLatched;
    logic              wbEnable;
    logic              reloadEnable;
    logic              mapOverride;
    logic              mapSelReg;
    logic              out18;
    logic              dual;
    logic [1:0]        depth;
    logic [1:0]        page;
    logic [1:0]        lastPage;
    logic              initDone;
    logic              reloaded;
    logic [2:0]        tableFull;
    logic              orderError;
    logic [DATA_W-1:0] rdData;
  } wbl_top_state_t;

  wbl_top_state_t    q;
  wbl_top_state_t    next_q;
  wbl_lut_wr_t       lutWr;
  wbl_fmt_t          fmt;
  wbl_pixel_t        lutPix;
  logic              lutValid;
  logic [DATA_W-1:0] lutRdata;
  logic              clkFall;
  logic              lutWriteOk;
  logic              effMapSel;

  function automatic logic isLutAddr(input logic [ADDR_W-1:0] a);
    return (a >= LUT_BASE) && (a <= LUT_LAST);
  endfunction

  function automatic logic [LUT_IDX_W-1:0] lutIdx(input logic [ADDR_W-1:0] a);
    return a[LUT_IDX_W-1:0];
  endfunction

  // data launch at the rising edge, so take it mid-period where it is settled
  assign clkFall = q.clkPrev && !q.clkSync;

  // writes open until the first enable, then only with reload allowed
  assign lutWriteOk = (!q.initDone || q.reloadEnable) && (q.page <= PAGE_BLUE);

  always_comb begin
    lutWr = '0;
    if (regWrite && isLutAddr(regAddr) && lutWriteOk) begin
      lutWr.en   = 1'b1;
      lutWr.page = q.page;
      lutWr.idx  = lutIdx(regAddr);
      lutWr.data = regWdata;
    end
  end

  assign effMapSel = q.mapOverride ? q.mapSelReg : q.strapLatched;

  always_comb begin
    fmt = '0;
    fmt.bit_map_select = effMapSel;
    fmt.out18  = q.out18;
    fmt.dual   = q.dual;
  end

  always_comb begin
    next_q = q;
    // synchronisers: first stage feeds only the second
    next_q.clkMeta   = pixClkIn;
    next_q.clkSync   = q.clkMeta;
    next_q.clkPrev   = q.clkSync;
    next_q.pixMeta   = pixIn;
    next_q.pixSync   = q.pixMeta;
    next_q.strapMeta = output_mode_strap;
    next_q.strapSync = q.strapMeta;

    next_q.capValid = clkFall;
    if (clkFall) begin
      next_q.pixCap = q.pixSync;
    end

    // strap is read once, after the synchroniser has filled
    if (q.strapWait != STRAP_SETTLE) begin
      next_q.strapWait = q.strapWait + 2'h1;
      if (q.strapWait + 2'h1 == STRAP_SETTLE) begin
        next_q.strapLatched = q.strapSync;
      end
    end

    if (regWrite) begin
      if (regAddr == REG_CTRL) begin
        next_q.wbEnable     = regWdata[CTRL_WB_EN];
        next_q.reloadEnable = regWdata[CTRL_RELOAD];
        next_q.mapOverride  = regWdata[CTRL_MAP_OVR];
        next_q.mapSelReg    = regWdata[CTRL_MAP_SEL];
        next_q.out18        = regWdata[CTRL_OUT18];
        next_q.dual         = regWdata[CTRL_DUAL];
        next_q.depth        = regWdata[CTRL_DEPTH +: 2];
        if (regWdata[CTRL_WB_EN]) begin
          next_q.initDone = 1'b1;
        end
      end else if (regAddr == REG_PAGE) begin
        next_q.page = regWdata[1:0];
      end
    end

    if (lutWr.en) begin
      if (q.initDone) begin
        next_q.reloaded = 1'b1;
      end else if (lutWr.page < q.lastPage) begin
        // initial load wandered back to an earlier table
        next_q.orderError = 1'b1;
      end
      if (!q.initDone) begin
        next_q.lastPage = lutWr.page;
      end
      if (lutWr.idx == LAST_ENTRY) begin
        next_q.tableFull[lutWr.page] = 1'b1;
      end
    end

    // read data stands only in the cycle after the strobe
    next_q.rdData = '0;
    if (regRead) begin
      if (regAddr == REG_CTRL) begin
        next_q.rdData[CTRL_WB_EN]     = q.wbEnable;
        next_q.rdData[CTRL_RELOAD]    = q.reloadEnable;
        next_q.rdData[CTRL_MAP_OVR]   = q.mapOverride;
        next_q.rdData[CTRL_MAP_SEL]   = q.mapSelReg;
        next_q.rdData[CTRL_OUT18]     = q.out18;
        next_q.rdData[CTRL_DUAL]      = q.dual;
        next_q.rdData[CTRL_DEPTH +: 2] = q.depth;
      end else if (regAddr == REG_PAGE) begin
        next_q.rdData[1:0] = q.page;
      end else if (regAddr == REG_STATUS) begin
        next_q.rdData[STAT_INIT]      = q.initDone;
        next_q.rdData[STAT_RELOAD]    = q.reloaded;
        next_q.rdData[STAT_LOCKED]    = q.initDone && !q.reloadEnable;
        next_q.rdData[STAT_STRAP]     = q.strapLatched;
        next_q.rdData[STAT_FULL +: 3] = q.tableFull;
        next_q.rdData[STAT_ORDER]     = q.orderError;
      end else if (isLutAddr(regAddr) && !q.reloaded) begin
        next_q.rdData = lutRdata;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign regRdata = q.rdData;

  wbl_lut_bank u_lut (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .lutWr    (lutWr),
    .busPage  (q.page),
    .busIdx   (lutIdx(regAddr)),
    .busRdata (lutRdata),
    .inValid  (q.capValid),
    .inPix    (q.pixCap),
    .wbEnable (q.wbEnable),
    .depth    (q.depth),
    .outValid (lutValid),
    .outPix   (lutPix)
  );

  wbl_frame_former u_frame (
    .core_clk    (core_clk),
    .sys_rst     (sys_rst),
    .inValid     (lutValid),
    .inPix       (lutPix),
    .fmt         (fmt),
    .linkA       (linkA),
    .linkB       (linkB),
    .clkOutA     (lvds_clock_out_a),
    .clkOutB     (lvds_clock_out_b),
    .frameStrobe (frameStrobe)
  );

  property p_frame_per_pixel;
    @(posedge core_clk) disable iff (sys_rst)
    clkFall |-> ##3 frameStrobe;
  endproperty
  a_frame_per_pixel: assert property (p_frame_per_pixel) else $error("frame missing");

  property p_single_frame;
    @(posedge core_clk) disable iff (sys_rst)
    frameStrobe |=> !frameStrobe;
  endproperty
  a_single_frame: assert property (p_single_frame) else $error("frame doubled");

  property p_clock_word;
    @(posedge core_clk) disable iff (sys_rst)
    frameStrobe |-> (lvds_clock_out_a == CLK_PATTERN);
  endproperty
  a_clock_word: assert property (p_clock_word) else $error("clock word wrong");

  property p_refuse;
    @(posedge core_clk) disable iff (sys_rst)
    regWrite && isLutAddr(regAddr) && q.initDone && !q.reloadEnable |-> !lutWr.en;
  endproperty
  a_refuse: assert property (p_refuse) else $error("locked table written");

  property p_reload_ok;
    @(posedge core_clk) disable iff (sys_rst)
    regWrite && isLutAddr(regAddr) && q.initDone && q.reloadEnable
      && (q.page <= PAGE_BLUE) |-> lutWr.en ##1 q.reloaded;
  endproperty
  a_reload_ok: assert property (p_reload_ok) else $error("reload write lost");

  property p_page_route;
    @(posedge core_clk) disable iff (sys_rst)
    lutWr.en |-> (lutWr.page == q.page) && (lutWr.data == regWdata);
  endproperty
  a_page_route: assert property (p_page_route) else $error("wrong table page");

  property p_no_readback;
    @(posedge core_clk) disable iff (sys_rst)
    regRead && isLutAddr(regAddr) && q.reloaded |=> (regRdata == 8'h00);
  endproperty
  a_no_readback: assert property (p_no_readback) else $error("read-back after reload");

  property p_map_source;
    @(posedge core_clk) disable iff (sys_rst)
    !q.mapOverride |-> (effMapSel == q.strapLatched);
  endproperty
  a_map_source: assert property (p_map_source) else $error("map source wrong");
endmodule

// [dv/wbl_panel_model.sv]
// panel model: captures lane frames, checks clock words and frame spacing
`timescale 1ns/100ps
module wbl_panel_model (
  input  wire logic                  core_clk,
  input  wire logic                  sys_rst,
  input  wire logic                  frameStrobe,
  input  wire wbl_pkg::wbl_link_t    linkA,
  input  wire logic [wbl_pkg::LANE_W-1:0] clkA,
  output wbl_pkg::wbl_link_t         seenA,
  output int                         faults
);
  import wbl_pkg::*;
  int gap;
  always @(posedge core_clk) begin
    if (sys_rst) begin
      gap <= 0;
      faults <= 0;
      seenA <= '0;
    end else if (frameStrobe) begin
      seenA <= linkA;
      gap <= 1;
      // a panel latches its clock lane per frame; any other shape loses lock
      if (clkA !== CLK_PATTERN || (gap != 0 && gap != 8)) faults <= faults + 1;
    end else if (gap != 0) begin
      gap <= gap + 1;
    end
  end
endmodule

// [dv/wbl_pixel_out_test.sv]
// self-checking bench for the white-balance pixel output path
`timescale 1ns/100ps
module wbl_pixel_out_test;
  import wbl_pkg::*;
  localparam wbl_pixel_t P0 = {1'b0, 1'b1, 1'b1, 8'h3C, 8'hC3, 8'h81};
  logic              core_clk = 1'b0;
  logic              sys_rst = 1'b1;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [DATA_W-1:0] regWdata = '0;
  logic              regWrite = 1'b0;
  logic              regRead = 1'b0;
  logic [DATA_W-1:0] regRdata;
  logic              pixClkIn = 1'b0;
  wbl_pixel_t        pixIn = '0;
  wbl_pixel_t        pixNext = '0;
  wbl_pixel_t        p;
  logic              output_mode_strap = 1'b1;
  wbl_link_t         linkA;
  wbl_link_t         linkB;
  wbl_link_t         seenA;
  logic [LANE_W-1:0] clkOutA;
  logic [LANE_W-1:0] clkOutB;
  logic              frameStrobe;
  logic [2:0]        pixDiv = '0;
  logic [7:0]        rd;
  int                faults;
  int                miscompares = 0;
  int                checks = 0;
  int                cycles = 0;

  wbl_pixel_out dut (.core_clk(core_clk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .pixClkIn(pixClkIn), .pixIn(pixIn), .output_mode_strap(output_mode_strap),
    .linkA(linkA), .linkB(linkB), .lvds_clock_out_a(clkOutA),
    .lvds_clock_out_b(clkOutB), .frameStrobe(frameStrobe));
  wbl_panel_model panel (.core_clk(core_clk), .sys_rst(sys_rst),
    .frameStrobe(frameStrobe), .linkA(linkA), .clkA(clkOutA), .seenA(seenA),
    .faults(faults));

  always #20 core_clk = ~core_clk;

  // pixel clock of 8 core cycles; data launched on its rising edge
  always @(posedge core_clk) begin
    pixDiv <= pixDiv + 3'h1;
    pixClkIn <= pixDiv[2];
    if (pixDiv == 3'h4) pixIn <= pixNext;
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      miscompares++;
      complete_run();
    end
  end

  task automatic complete_run;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chkLink(input wbl_link_t got, input wbl_link_t exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask

  task automatic rdr(input logic [ADDR_W-1:0] a);
    @(posedge core_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1 rd = regRdata;
  endtask

  task automatic frames(input int n);
    repeat (n) @(posedge core_clk iff frameStrobe);
    #1;
  endtask

  function automatic logic [7:0] lutv(input int pg, input logic [7:0] i);
    // distinct per table so a misrouted page shows up
    if (pg == 0) return i ^ 8'h5A;
    if (pg == 1) return i ^ 8'hA5;
    return ~i;
  endfunction

  function automatic wbl_link_t mapx(input logic hi, input wbl_pixel_t q);
    wbl_link_t l;
    if (hi) begin
      l.lane0 = {q.g[0], q.r[5:0]};
      l.lane1 = {q.b[1:0], q.g[5:1]};
      l.lane2 = {q.de, q.vsync, q.hsync, q.b[5:2]};
      l.lane3 = {1'b0, q.b[7:6], q.g[7:6], q.r[7:6]};
    end else begin
      l.lane0 = {q.g[2], q.r[7:2]};
      l.lane1 = {q.b[3:2], q.g[7:3]};
      l.lane2 = {q.de, q.vsync, q.hsync, q.b[7:4]};
      l.lane3 = {1'b0, q.b[1:0], q.g[1:0], q.r[1:0]};
    end
    return l;
  endfunction

  task automatic t_load;
    for (int pg = 0; pg < 3; pg++) begin
      wr(REG_PAGE, 8'(pg));
      for (int i = 0; i < 256; i++) wr(LUT_BASE + ADDR_W'(i), lutv(pg, 8'(i)));
    end
    wr(REG_PAGE, 8'h02);
    rdr(LUT_BASE + 10'h017);
    chk8(rd, lutv(2, 8'h17));
    wr(REG_PAGE, 8'h00);
    rdr(LUT_BASE + 10'h03C);
    chk8(rd, lutv(0, 8'h3C));
    rdr(REG_STATUS);
    chk8(rd, 8'h78);
    $display("test load done");
  endtask

  task automatic t_map;
    pixNext = P0;
    wr(REG_CTRL, 8'h04);
    frames(4);
    chkLink(seenA, mapx(1'b0, P0));
    chkLink(linkB, '0);
    chk8({1'b0, clkOutA}, 8'h63);
    chk8({1'b0, clkOutB}, 8'h00);
    wr(REG_CTRL, 8'h00);
    frames(4);
    chkLink(seenA, mapx(1'b1, P0));
    wr(REG_CTRL, 8'h10);
    frames(4);
    p = P0;
    p.r = p.r >> 2;
    p.g = p.g >> 2;
    p.b = p.b >> 2;
    chkLink(seenA, mapx(1'b1, p));
    $display("test map done");
  endtask

  task automatic t_wb;
    wr(REG_CTRL, 8'h01);
    frames(4);
    p = P0;
    p.r = lutv(0, 8'h3C);
    p.g = lutv(1, 8'hC3);
    p.b = lutv(2, 8'h81);
    chkLink(seenA, mapx(1'b1, p));
    rdr(REG_STATUS);
    chk8(rd, 8'h7D);
    wr(LUT_BASE + 10'h03C, 8'h11);
    rdr(LUT_BASE + 10'h03C);
    chk8(rd, lutv(0, 8'h3C));
    wr(REG_CTRL, 8'h03);
    wr(LUT_BASE + 10'h03C, 8'h11);
    frames(4);
    p.r = 8'h11;
    chkLink(seenA, mapx(1'b1, p));
    rdr(LUT_BASE + 10'h03C);
    chk8(rd, 8'h00);
    rdr(REG_STATUS);
    chk8(rd, 8'h7B);
    $display("test white balance done");
  endtask

  task automatic t_depth;
    pixNext.r = 8'h3F;
    wr(REG_CTRL, 8'h43); // dither sits downstream, the 8-bit result leaves here
    frames(4);
    p.g = lutv(1, 8'hC0);
    p.b = lutv(2, 8'h80);
    chkLink(seenA, mapx(1'b1, p));
    wr(REG_CTRL, 8'h83);
    wr(LUT_BASE + 10'h038, 8'hA8);
    frames(4);
    p.r = 8'hA8;
    chkLink(seenA, mapx(1'b1, p));
    chk8(faults[7:0], 8'h00);
    $display("test depth done");
  endtask

  task automatic t_dual;
    wbl_pixel_t lo;
    lo = P0;
    lo.de = 1'b0;
    pixNext = lo;
    wr(REG_CTRL, 8'h20);
    frames(3);
    pixNext = P0;
    frames(2);
    chkLink(linkA, mapx(1'b1, P0));
    chkLink(linkB, mapx(1'b1, lo));
    frames(1);
    chkLink(linkB, mapx(1'b1, P0));
    chk8({1'b0, clkOutB}, 8'h63);
    $display("test dual done");
  endtask

  initial begin
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    // strap is latched only three cycles after release
    repeat (4) @(posedge core_clk);
    rdr(REG_STATUS);
    chk8(rd, 8'h08);
    rdr(10'h3FF);
    chk8(rd, 8'h00);
    $display("test reset done");
    t_load();
    t_map();
    t_wb();
    t_depth();
    t_dual();
    complete_run();
  end
endmodule
